/* rifd_consts.svh */
// constants for the instruction format decoder
`ifndef RIFD_CONSTS_SVH
`define RIFD_CONSTS_SVH
`define RIFD_WORD_W 14
`define RIFD_FILE_W 7
`define RIFD_DATA_W 8
`define RIFD_BIT_W 3
`define RIFD_LIT8_W 8
`define RIFD_LIT11_W 11
`define RIFD_PC_W 13
`define RIFD_CLASS_HI 13
`define RIFD_CLASS_LO 12
`define RIFD_OP_HI 11
`define RIFD_OP_LO 8
`define RIFD_DEST_BIT 7
`define RIFD_BITSEL_HI 9
`define RIFD_BITSEL_LO 7
`define RIFD_GOTO_BIT 11
`define RIFD_CLS_BYTE 2'h0
`define RIFD_CLS_BIT 2'h1
`define RIFD_CLS_JUMP 2'h2
`define RIFD_CLS_LIT 2'h3
`define RIFD_OP_MOVWF 4'h0
`define RIFD_OP_CLR 4'h1
`define RIFD_OP_DECFSZ 4'hb
`define RIFD_OP_INCFSZ 4'hf
`define RIFD_OP_BTFSC 2'h2
`define RIFD_OP_BTFSS 2'h3
`define RIFD_LOP_RETLW 2'h1
`define RIFD_CTL_RETURN 14'h0008
`define RIFD_CTL_RETFIE 14'h0009
`define RIFD_PHASES 2'h3
`define RIFD_PH_TAKE 2'h0
`define RIFD_PH_READ 2'h1
`define RIFD_PH_STORE 2'h2
`define RIFD_CTL_PREFIX 5'h00
`define RIFD_PORTA_ADDR 7'h05
`endif

/* rifd_pkg.sv */
// types for the instruction format decoder
package rifd_pkg;
	typedef enum logic [2:0]
	{
		RIFD_BYTE = 3'h1,
		RIFD_BITOP = 3'h2,
		RIFD_LITCTL = 3'h4
	} rifd_class_e;
	typedef enum logic [1:0]
	{
		RIFD_ST_EXEC = 2'h1,
		RIFD_ST_IDLE = 2'h2
	} rifd_state_e;
endpackage

/* rifd_decoder.sv */
// instruction format decoder with cycle timing and read-modify-write
// What this block does
// RULE_01: each instruction is one 14-bit word of opcode and operand fields
// RULE_02: every instruction falls in exactly one of three classes
// RULE_03: byte operations yield a file address and a one-bit target select
// RULE_04: target 0 writes the accumulator, target 1 writes the file register
// RULE_05: file address is seven instruction bits, 0x00 to 0x7f
// RULE_06: bit operations yield a three-bit position and a file address
// RULE_07: literal is eight bits, or eleven bits for jump and call
// RULE_08: one instruction cycle lasts four clock periods
// RULE_09: branches and true skips take a second cycle run as an idle slot
// RULE_10: file instructions read, modify, then store to the chosen target
// RULE_11: the read happens even for write-only instructions like clear
// RULE_12: clearing port a reads it first, clearing the change mismatch
// RULE_13: don't-care bits are ignored, either value accepted
// RULE_14: accumulator target leaves the file register unwritten
`timescale 1ns/10ps
`include "rifd_consts.svh"
module rifd_decoder
	import rifd_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [`RIFD_WORD_W-1:0] INSTR,
	input wire logic [`RIFD_DATA_W-1:0] FILE_RDATA,
	input wire logic [`RIFD_DATA_W-1:0] ALU_RESULT,
	input wire logic SKIP_COND,
	output logic INSTR_FETCH,
	output logic [2:0] INSTR_CLASS,
	output logic [`RIFD_FILE_W-1:0] FILE_ADDR,
	output logic DEST_FILE,
	output logic [`RIFD_BIT_W-1:0] BIT_SEL,
	output logic [`RIFD_LIT11_W-1:0] LITERAL,
	output logic FILE_RD,
	output logic FILE_WR,
	output logic [`RIFD_DATA_W-1:0] FILE_WDATA,
	output logic ACC_WR,
	output logic [`RIFD_DATA_W-1:0] ACC_WDATA,
	output logic IDLE_SLOT,
	output logic PORTA_READ
);
	logic [1:0] phase;
	rifd_state_e state;
	logic [`RIFD_WORD_W-1:0] ir;
	logic [`RIFD_DATA_W-1:0] read_value;
	logic [1:0] cls;
	logic uses_file;
	logic to_file;
	logic pc_change;
	logic is_skip;
	logic cycle_end;
	logic take_slot;
	logic read_slot;
	logic store_slot;
	rifd_class_e next_class;

	// class and field split
	assign cls = ir[`RIFD_CLASS_HI:`RIFD_CLASS_LO];
	assign cycle_end = (phase == `RIFD_PHASES);
	// RULE_08 phase slots
	assign take_slot = (phase == `RIFD_PH_TAKE);
	assign read_slot = (phase == `RIFD_PH_READ) && uses_file && (state == RIFD_ST_EXEC);
	assign store_slot = (phase == `RIFD_PH_STORE) && uses_file && (state == RIFD_ST_EXEC);

	// RULE_02 one class each
	always_comb
	begin
		case (cls)
			`RIFD_CLS_BYTE: next_class = RIFD_BYTE;
			`RIFD_CLS_BIT: next_class = RIFD_BITOP;
			default: next_class = RIFD_LITCTL;
		endcase
	end

	// RULE_10 file operand present
	always_comb
	begin
		uses_file = 1'b0;
		to_file = 1'b0;
		if (cls == `RIFD_CLS_BYTE)
		begin
			uses_file = (ir[`RIFD_OP_HI:`RIFD_OP_LO] != `RIFD_OP_MOVWF) || ir[`RIFD_DEST_BIT];
			// RULE_04 target select
			to_file = ir[`RIFD_DEST_BIT];
		end
		else if (cls == `RIFD_CLS_BIT)
		begin
			uses_file = 1'b1;
			to_file = (ir[`RIFD_OP_HI:`RIFD_BITSEL_HI+1] != `RIFD_OP_BTFSC) &&
				(ir[`RIFD_OP_HI:`RIFD_BITSEL_HI+1] != `RIFD_OP_BTFSS);
		end
	end

	// RULE_09 two-cycle conditions
	always_comb
	begin
		is_skip = 1'b0;
		pc_change = 1'b0;
		if (cls == `RIFD_CLS_BYTE)
			is_skip = (ir[`RIFD_OP_HI:`RIFD_OP_LO] == `RIFD_OP_DECFSZ) ||
				(ir[`RIFD_OP_HI:`RIFD_OP_LO] == `RIFD_OP_INCFSZ);
		else if (cls == `RIFD_CLS_BIT)
			is_skip = !to_file;
		if (cls == `RIFD_CLS_JUMP)
			pc_change = 1'b1;
		else if (cls == `RIFD_CLS_LIT)
			pc_change = (ir[`RIFD_OP_HI:`RIFD_OP_HI-1] == `RIFD_LOP_RETLW);
		// RULE_13 don't-care bits ignored
		else if (cls == `RIFD_CLS_BYTE && ir[`RIFD_OP_HI:`RIFD_DEST_BIT] == `RIFD_CTL_PREFIX)
			pc_change = (ir == `RIFD_CTL_RETURN) || (ir == `RIFD_CTL_RETFIE);
	end

	// RULE_08 four-period cycle
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end

	// RULE_09 idle slot sequencing
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			state <= RIFD_ST_EXEC;
		else if (cycle_end)
		begin
			case (state)
				RIFD_ST_EXEC: state <= (pc_change || (is_skip && SKIP_COND)) ? RIFD_ST_IDLE : RIFD_ST_EXEC;
				RIFD_ST_IDLE: state <= RIFD_ST_EXEC;
				default: state <= RIFD_ST_EXEC;
			endcase
		end
	end

	// RULE_01 latch 14-bit word
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ir <= {`RIFD_WORD_W{1'b0}};
			INSTR_FETCH <= 1'b0;
		end
		else
		begin
			INSTR_FETCH <= take_slot;
			if (take_slot)
				ir <= INSTR;
		end
	end

	// RULE_03 operand fields
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			INSTR_CLASS <= RIFD_LITCTL;
			FILE_ADDR <= {`RIFD_FILE_W{1'b0}};
			DEST_FILE <= 1'b0;
			BIT_SEL <= {`RIFD_BIT_W{1'b0}};
			LITERAL <= {`RIFD_LIT11_W{1'b0}};
			IDLE_SLOT <= 1'b0;
		end
		else
		begin
			INSTR_CLASS <= next_class;
			// RULE_05 seven address bits
			FILE_ADDR <= ir[`RIFD_FILE_W-1:0];
			DEST_FILE <= to_file && (state == RIFD_ST_EXEC);
			// RULE_06 bit position
			BIT_SEL <= ir[`RIFD_BITSEL_HI:`RIFD_BITSEL_LO];
			// RULE_07 literal width
			if (cls == `RIFD_CLS_JUMP)
				LITERAL <= ir[`RIFD_LIT11_W-1:0];
			else
				LITERAL <= {3'h0, ir[`RIFD_LIT8_W-1:0]};
			IDLE_SLOT <= (state == RIFD_ST_IDLE);
		end
	end

	// RULE_10 read-modify-write
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			FILE_RD <= 1'b0;
			PORTA_READ <= 1'b0;
			read_value <= {`RIFD_DATA_W{1'b0}};
		end
		else
		begin
			// RULE_11 read always performed
			FILE_RD <= read_slot;
			// RULE_12 port a read side effect
			PORTA_READ <= read_slot && (ir[`RIFD_FILE_W-1:0] == `RIFD_PORTA_ADDR);
			if (FILE_RD)
				read_value <= FILE_RDATA;
		end
	end

	// RULE_10 store result
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			FILE_WR <= 1'b0;
			FILE_WDATA <= {`RIFD_DATA_W{1'b0}};
			ACC_WR <= 1'b0;
			ACC_WDATA <= {`RIFD_DATA_W{1'b0}};
		end
		else
		begin
			// RULE_14 no file write to accumulator
			FILE_WR <= store_slot && to_file;
			// RULE_04 accumulator result
			ACC_WR <= store_slot && (cls == `RIFD_CLS_BYTE) && !to_file;
			FILE_WDATA <= ALU_RESULT;
			ACC_WDATA <= ALU_RESULT;
		end
	end
endmodule

/* rifd_decoder_asserts.sv */
// timing checker for the instruction format decoder
`timescale 1ns/10ps
`include "rifd_consts.svh"
module rifd_decoder_asserts
	import rifd_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [`RIFD_DATA_W-1:0] ALU_RESULT,
	input wire logic INSTR_FETCH,
	input wire logic [2:0] INSTR_CLASS,
	input wire logic [`RIFD_FILE_W-1:0] FILE_ADDR,
	input wire logic DEST_FILE,
	input wire logic FILE_RD,
	input wire logic FILE_WR,
	input wire logic [`RIFD_DATA_W-1:0] FILE_WDATA,
	input wire logic ACC_WR,
	input wire logic IDLE_SLOT,
	input wire logic PORTA_READ
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	fetch_period_a: assert property (INSTR_FETCH |=> !INSTR_FETCH [*3] ##1 INSTR_FETCH)
		else $error("fetch spacing wrong");
	class_onehot_a: assert property ($onehot(INSTR_CLASS))
		else $error("class not one-hot");
	rd_after_fetch_a: assert property (FILE_RD |-> $past(INSTR_FETCH) && !IDLE_SLOT)
		else $error("read strobe misplaced");
	wr_after_rd_a: assert property (FILE_WR || ACC_WR |-> $past(FILE_RD))
		else $error("write without read");
	acc_target_a: assert property (ACC_WR |-> INSTR_CLASS == 3'h1 && !DEST_FILE)
		else $error("bad accumulator write");
	acc_nofile_a: assert property (ACC_WR |-> !FILE_WR)
		else $error("file written with accumulator");
	idle_quiet_a: assert property (IDLE_SLOT |-> !FILE_RD && !FILE_WR && !ACC_WR)
		else $error("strobe in idle slot");
	idle_len_a: assert property ($rose(IDLE_SLOT) |-> IDLE_SLOT [*4] ##1 !IDLE_SLOT)
		else $error("idle slot length");
	porta_read_a: assert property (PORTA_READ == (FILE_RD && FILE_ADDR == `RIFD_PORTA_ADDR))
		else $error("port read flag wrong");
	wdata_lag_a: assert property (FILE_WR |-> FILE_WDATA == $past(ALU_RESULT))
		else $error("write data stale");
	cover property (ACC_WR);
	cover property (PORTA_READ);
	cover property ($rose(IDLE_SLOT));
endmodule
bind rifd_decoder rifd_decoder_asserts u_chk (.MCLK, .RESETN, .ALU_RESULT, .INSTR_FETCH, .INSTR_CLASS, .FILE_ADDR,
	.DEST_FILE, .FILE_RD, .FILE_WR, .FILE_WDATA, .ACC_WR, .IDLE_SLOT, .PORTA_READ);

/* rifd_pmem.sv */
// program memory model feeding instruction words
`timescale 1ns/10ps
module rifd_pmem
	import rifd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fetch,
	input wire logic [13:0] next_word,
	output logic [13:0] word
);
	// new word once the current one is taken
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			word <= 14'h0000;
		else if (fetch)
			word <= next_word;
	end
endmodule

/* rifd_decoder_tb.sv */
// random bench for the instruction format decoder
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t mismatch", $time); end end
module rifd_decoder_tb
	import rifd_pkg::*;
;
	logic MCLK = 0, RESETN = 0, SKIP_COND = 0, s, pend = 0, rx = 0;
	logic INSTR_FETCH, DEST_FILE, FILE_RD, FILE_WR, ACC_WR, IDLE_SLOT, PORTA_READ;
	logic [13:0] INSTR, next_word = 0;
	logic [13:0] corner [8] = '{14'h0185, 14'h017f, 14'h0b7f, 14'h1d85, 14'h2fff, 14'h3400, 14'h0008, 14'h3fff};
	logic [7:0] FILE_RDATA = 0, ALU_RESULT = 0, FILE_WDATA, ACC_WDATA;
	logic [6:0] FILE_ADDR;
	logic [2:0] INSTR_CLASS, BIT_SEL;
	logic [10:0] LITERAL;
	logic [1:0] w1 = 0, w2 = 0;
	logic fv = 0;
	logic [13:0] iw = 0;
	logic [7:0] alu_d = 0;
	logic [2:0] e;
	logic [31:0] lf = 32'h4f88;
	int err_count = 0, n_checks = 0, n = 0;
	always #5 MCLK = ~MCLK;
	rifd_decoder DUT (.MCLK, .RESETN, .INSTR, .FILE_RDATA, .ALU_RESULT, .SKIP_COND, .INSTR_FETCH, .INSTR_CLASS, .FILE_ADDR,
		.DEST_FILE, .BIT_SEL, .LITERAL, .FILE_RD, .FILE_WR, .FILE_WDATA, .ACC_WR, .ACC_WDATA, .IDLE_SLOT, .PORTA_READ);
	rifd_pmem u_pmem (.clk(MCLK), .rst_n(RESETN), .fetch(INSTR_FETCH), .next_word, .word(INSTR));
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic two_cyc(logic [13:0] w, logic c);
		return w[13:12] == 2'h2 || w[13:10] == 4'hd || w == 14'h0008 || w == 14'h0009
			|| (c && w[11] && (w[13:12] == 2'h1 || (w[13:12] == 2'h0 && w[9:8] == 2'h3)));
	endfunction
	function automatic logic byte_op(logic [13:0] w);
		return w[13:12] == 2'h0 && w[11:8] != 4'h0;
	endfunction
	function automatic logic [2:0] strobes(logic [13:0] w);
		logic bo, bt;
		bo = w[13:12] == 2'h0;
		bt = w[13:12] == 2'h1;
		return {(bo && (w[11:8] != 4'h0 || w[7])) || bt, (bo && w[7]) || (bt && !w[11]), byte_op(w) && !w[7]};
	endfunction
	task automatic summarize();
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge MCLK)
	begin
		lf = lfsr(lf);
		s = lf[20];
		e = INSTR_FETCH && !IDLE_SLOT ? strobes(INSTR) : 3'h0;
		FILE_RDATA <= lf[7:0];
		ALU_RESULT <= lf[15:8];
		alu_d <= ALU_RESULT;
		iw <= INSTR;
		fv <= INSTR_FETCH && !IDLE_SLOT;
		rx <= e[2];
		w1 <= e[1:0];
		w2 <= w1;
		`CHK(ACC_WR, w2[0])
		`CHK(FILE_WR, w2[1])
		`CHK(FILE_RD, rx)
		`CHK(PORTA_READ, rx && iw[6:0] == 7'h05)
		if (w2[1]) `CHK(FILE_WDATA, alu_d)
		if (w2[0]) `CHK(ACC_WDATA, alu_d)
		if (INSTR_FETCH)
		begin
			`CHK(IDLE_SLOT, pend)
			pend <= !IDLE_SLOT && two_cyc(INSTR, s);
			SKIP_COND <= s;
			next_word <= n < 8 ? corner[n] : lf[29:16];
			n++;
		end
		if (fv)
		begin
			`CHK(INSTR_CLASS, iw[13] ? 3'h4 : iw[12] ? 3'h2 : 3'h1)
			`CHK(FILE_ADDR, iw[6:0])
			`CHK(BIT_SEL, iw[9:7])
			`CHK(LITERAL, iw[13:12] == 2'h2 ? iw[10:0] : {3'h0, iw[7:0]})
			if (byte_op(iw)) `CHK(DEST_FILE, iw[7])
		end
	end
	initial
	begin
		repeat (12) @(posedge MCLK);
		RESETN <= 1'b1;
		repeat (1600) @(posedge MCLK);
		summarize();
	end
	initial
	begin
		#30000;
		err_count++;
		summarize();
	end
endmodule
